// ---- verilog/sem_reg_bank.sv ----
// Error mask, error status and device configuration register bank
module sem_reg_bank (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [31:0] err_event,
   input wire logic sleep_active,
   input wire logic [31:0] dev_flags_in,
   input wire logic [31:0] ctrl_flags_in,
   input wire logic wake_pin,
   output logic [31:0] err_status,
   output logic [31:0] mode_setup,
   output logic [31:0] timestamp_prescale,
   output logic [31:0] interrupt_enables,
   output logic spi_error_irq,
   output logic internal_error_irq,
   output logic wake_event
);
   logic [31:0] err_mask;
   logic [31:0] scratch_test_word;
   logic [31:0] ecc_test0;
   logic [31:0] ecc_test1;
   logic [31:0] device_interrupt_flags;
   logic [31:0] controller_interrupt_flags;
   logic sleep_q;
   logic sleep_entry;
   logic [31:0] next_err_status;
   logic [31:0] next_err_mask;
   logic [31:0] next_mode_setup;
   logic [31:0] next_prescale;
   logic [31:0] next_scratch;
   logic [31:0] next_ecc0;
   logic [31:0] next_ecc1;
   logic [31:0] next_dev_flags;
   logic [31:0] next_ctrl_flags;
   logic [31:0] next_int_en;
   logic next_spi_irq;
   logic next_int_irq;
   logic [31:0] next_rdata;
   logic [31:0] status_view;
   logic [31:0] w1c_vec;

   // ==========================================================
   // Error status and mask
   always_comb begin
      w1c_vec = (reg_wr && reg_addr == sem_pkg::OFS_ERR_STATUS) ? reg_wdata : sem_pkg::RST_ZERO;
      // sticky, write one clears, set wins
      next_err_status = ((err_status & ~w1c_vec) | err_event) & sem_pkg::ERR_BITS;
      next_err_mask = err_mask;
      if (reg_wr && reg_addr == sem_pkg::OFS_ERR_MASK) begin
         next_err_mask = reg_wdata & sem_pkg::ERR_BITS;
      end
      next_spi_irq = |(next_err_status & ~next_err_mask & sem_pkg::SPI_ERR_BITS);
      next_int_irq = |(next_err_status & ~next_err_mask & sem_pkg::INT_ERR_BITS);
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         err_status <= sem_pkg::RST_ZERO;
         err_mask <= sem_pkg::RST_ZERO;
         spi_error_irq <= 1'b0;
         internal_error_irq <= 1'b0;
      end else begin
         err_status <= next_err_status;
         err_mask <= next_err_mask;
         spi_error_irq <= next_spi_irq;
         internal_error_irq <= next_int_irq;
      end
   end

   // ==========================================================
   // Configuration region
   // Sleep entry wins over a write in the same cycle, so that the
   // lost bits really come back at their reset values.
   assign sleep_entry = sleep_active & ~sleep_q;

   always_comb begin
      next_mode_setup = mode_setup;
      next_prescale = timestamp_prescale;
      next_scratch = scratch_test_word;
      next_ecc0 = ecc_test0;
      next_ecc1 = ecc_test1;
      next_int_en = interrupt_enables;
      next_ctrl_flags = ctrl_flags_in;
      next_dev_flags = dev_flags_in;
      if (reg_wr) begin
         case (reg_addr)
            sem_pkg::OFS_MODE: begin
               next_mode_setup = (mode_setup & ~sem_pkg::MODE_WR_MASK)
                  | (reg_wdata & sem_pkg::MODE_WR_MASK);
            end
            sem_pkg::OFS_PRESCALE: next_prescale = reg_wdata;
            sem_pkg::OFS_SCRATCH: next_scratch = reg_wdata;
            sem_pkg::OFS_ECC0: next_ecc0 = reg_wdata;
            sem_pkg::OFS_ECC1: next_ecc1 = reg_wdata;
            sem_pkg::OFS_INT_EN: next_int_en = reg_wdata;
            default: next_int_en = interrupt_enables;
         endcase
      end
      if (sleep_active) begin
         // Flags freeze to their kept bits while asleep
         next_dev_flags = device_interrupt_flags & sem_pkg::RET_FLAGS;
      end
      if (sleep_entry) begin
         next_mode_setup = (mode_setup & sem_pkg::RET_MODE)
            | (sem_pkg::RST_MODE & ~sem_pkg::RET_MODE);
         next_int_en = (interrupt_enables & sem_pkg::RET_INT_EN)
            | (sem_pkg::RST_INT_EN & ~sem_pkg::RET_INT_EN);
         next_dev_flags = device_interrupt_flags & sem_pkg::RET_FLAGS;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mode_setup <= sem_pkg::RST_MODE;
         timestamp_prescale <= sem_pkg::RST_PRESCALE;
         scratch_test_word <= sem_pkg::RST_ZERO;
         ecc_test0 <= sem_pkg::RST_ZERO;
         ecc_test1 <= sem_pkg::RST_ZERO;
         interrupt_enables <= sem_pkg::RST_INT_EN;
         device_interrupt_flags <= sem_pkg::RST_ZERO;
         controller_interrupt_flags <= sem_pkg::RST_ZERO;
         sleep_q <= 1'b0;
      end else begin
         mode_setup <= next_mode_setup;
         timestamp_prescale <= next_prescale;
         scratch_test_word <= next_scratch;
         ecc_test0 <= next_ecc0;
         ecc_test1 <= next_ecc1;
         interrupt_enables <= next_int_en;
         device_interrupt_flags <= next_dev_flags;
         // Flag copies trail their inputs by one cycle
         controller_interrupt_flags <= next_ctrl_flags;
         sleep_q <= sleep_active;
      end
   end

   // ==========================================================
   // Read path
   always_comb begin
      // masked bits stay visible here
      // Summary bits ride in the low byte of the status word
      status_view = err_status;
      status_view[sem_pkg::SUM_SPI_BIT] = spi_error_irq;
      status_view[sem_pkg::SUM_INT_BIT] = internal_error_irq;
      case (reg_addr)
         sem_pkg::OFS_ERR_STATUS: next_rdata = status_view;
         sem_pkg::OFS_ERR_MASK: next_rdata = err_mask;
         sem_pkg::OFS_MODE: next_rdata = mode_setup;
         sem_pkg::OFS_PRESCALE: next_rdata = timestamp_prescale;
         sem_pkg::OFS_SCRATCH: next_rdata = scratch_test_word;
         sem_pkg::OFS_ECC0: next_rdata = ecc_test0;
         sem_pkg::OFS_ECC1: next_rdata = ecc_test1;
         sem_pkg::OFS_DEV_FLAGS: next_rdata = device_interrupt_flags;
         sem_pkg::OFS_CTRL_FLAGS: next_rdata = controller_interrupt_flags;
         sem_pkg::OFS_INT_EN: next_rdata = interrupt_enables;
         default: next_rdata = sem_pkg::RST_ZERO;
      endcase
      if (!reg_rd) begin
         next_rdata = reg_rdata;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= sem_pkg::RST_ZERO;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata <= next_rdata;
         reg_rvalid <= reg_rd;
      end
   end

   // ==========================================================
   // Wake pin
   // Pin is asynchronous; the detector synchronises it first
   sem_wake_detect u_wake (
      .mclk(mclk),
      .arst_n(arst_n),
      .wake_pin(wake_pin),
      .wake_cfg(mode_setup[sem_pkg::WAKE_LSB +: 2]),
      .wake_event(wake_event)
   );

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   a_err_set_wins: assert property (
      |(err_event & sem_pkg::ERR_BITS) |=>
         ((err_status & $past(err_event & sem_pkg::ERR_BITS))
            == $past(err_event & sem_pkg::ERR_BITS)))
      else $error("error event lost");
   a_err_w1c_clear: assert property (
      reg_wr && reg_addr == sem_pkg::OFS_ERR_STATUS && err_event == sem_pkg::RST_ZERO |=>
         (err_status & $past(reg_wdata)) == sem_pkg::RST_ZERO)
      else $error("write one did not clear error bit");
   a_err_sticky_hold: assert property (
      !(reg_wr && reg_addr == sem_pkg::OFS_ERR_STATUS) |=>
         ((err_status & $past(err_status)) == $past(err_status)))
      else $error("error bit dropped without a clear");
   a_mask_reserved_zero: assert property (
      (err_mask & ~sem_pkg::ERR_BITS) == sem_pkg::RST_ZERO)
      else $error("reserved mask bit set");
   a_spi_summary_match: assert property (
      ##1 spi_error_irq == |(err_status & ~err_mask & sem_pkg::SPI_ERR_BITS))
      else $error("spi error summary wrong");
   a_masked_still_set: assert property (
      |(err_event & err_mask & sem_pkg::SPI_ERR_BITS)
         && !(reg_wr && reg_addr == sem_pkg::OFS_ERR_MASK)
         ##1 !(reg_wr && (reg_addr == sem_pkg::OFS_ERR_STATUS
            || reg_addr == sem_pkg::OFS_ERR_MASK)) |=>
         |(err_status & err_mask & sem_pkg::SPI_ERR_BITS))
      else $error("masked error bit not kept");
   a_cfg_unmapped_zero: assert property (
      reg_rd && reg_addr >= sem_pkg::CFG_BASE && reg_addr <= sem_pkg::CFG_LAST
         && reg_addr[3:0] == 4'h4 && reg_addr[7:4] >= 4'h1 && reg_addr != sem_pkg::OFS_CTRL_FLAGS
         |=> reg_rvalid && reg_rdata == sem_pkg::RST_ZERO)
      else $error("unassigned config address read nonzero");
   a_mode_fixed_bits: assert property (
      (mode_setup & ~sem_pkg::MODE_WR_MASK) == (sem_pkg::RST_MODE & ~sem_pkg::MODE_WR_MASK))
      else $error("read-only mode bits changed");
   a_sleep_mode_keep: assert property (
      sleep_active && !sleep_q |=>
         mode_setup == (($past(mode_setup) & sem_pkg::RET_MODE)
            | (sem_pkg::RST_MODE & ~sem_pkg::RET_MODE)))
      else $error("mode bits not kept over sleep entry");
   a_sleep_flag_keep: assert property (
      sleep_active && !sleep_q |=>
         device_interrupt_flags == ($past(device_interrupt_flags) & sem_pkg::RET_FLAGS)
         && (interrupt_enables & sem_pkg::RET_INT_EN)
            == ($past(interrupt_enables) & sem_pkg::RET_INT_EN))
      else $error("flag or enable bits not kept over sleep");
   a_mask_hides_summary: assert property (
      (err_event & sem_pkg::SPI_ERR_BITS) != sem_pkg::RST_ZERO
         && (err_event & sem_pkg::SPI_ERR_BITS & ~err_mask) == sem_pkg::RST_ZERO
         && (err_status & ~err_mask & sem_pkg::SPI_ERR_BITS) == sem_pkg::RST_ZERO
         && !(reg_wr && reg_addr == sem_pkg::OFS_ERR_MASK) |=> !spi_error_irq)
      else $error("masked bit raised summary");

   // ==========================================================
   // Status, read port, write and sleep checks
   a_int_summary_match: assert property (
      ##1 internal_error_irq == |(err_status & ~err_mask & sem_pkg::INT_ERR_BITS))
      else $error("internal error summary wrong");
   a_status_reserved_zero: assert property (
      (err_status & ~sem_pkg::ERR_BITS) == sem_pkg::RST_ZERO)
      else $error("reserved status bit set");
   a_w1c_keeps_rest: assert property (
      reg_wr && reg_addr == sem_pkg::OFS_ERR_STATUS |=>
         ((err_status & $past(err_status & ~reg_wdata))
            == $past(err_status & ~reg_wdata)))
      else $error("write zero cleared an error bit");
   a_mask_write_lands: assert property (
      reg_wr && reg_addr == sem_pkg::OFS_ERR_MASK |=>
         err_mask == ($past(reg_wdata) & sem_pkg::ERR_BITS))
      else $error("mask write not stored");
   a_mask_read_reserved: assert property (
      reg_rd && reg_addr == sem_pkg::OFS_ERR_MASK |=>
         reg_rvalid && (reg_rdata & ~sem_pkg::ERR_BITS) == sem_pkg::RST_ZERO)
      else $error("reserved mask bit read nonzero");
   a_status_read_visible: assert property (
      reg_rd && reg_addr == sem_pkg::OFS_ERR_STATUS |=>
         reg_rvalid && (reg_rdata & sem_pkg::ERR_BITS) == $past(err_status))
      else $error("status read hides a set bit");
   a_mode_read_value: assert property (
      reg_rd && reg_addr == sem_pkg::OFS_MODE |=> reg_rdata == $past(mode_setup))
      else $error("mode register read wrong");
   a_mode_write_mask: assert property (
      reg_wr && reg_addr == sem_pkg::OFS_MODE && !(sleep_active && !sleep_q) |=>
         mode_setup == (($past(mode_setup) & ~sem_pkg::MODE_WR_MASK)
            | ($past(reg_wdata) & sem_pkg::MODE_WR_MASK)))
      else $error("mode write not applied through its mask");
   a_sleep_flags_frozen: assert property (
      sleep_active && sleep_q |=>
         device_interrupt_flags == $past(device_interrupt_flags))
      else $error("flags changed while asleep");
   a_sleep_enable_reset: assert property (
      sleep_active && !sleep_q |=>
         (interrupt_enables & ~sem_pkg::RET_INT_EN)
            == (sem_pkg::RST_INT_EN & ~sem_pkg::RET_INT_EN))
      else $error("lost enable bits not back at reset value");
   a_read_answer_once: assert property (
      reg_rd |=> reg_rvalid)
      else $error("read got no answer");
   a_no_spurious_answer: assert property (
      !reg_rd |=> !reg_rvalid)
      else $error("answer without a read");

   c_spi_irq: cover property (!spi_error_irq ##1 spi_error_irq);
   c_masked_err: cover property (|(err_status & err_mask));
   c_sleep_entry: cover property (sleep_active && !sleep_q);
   c_cfg_read: cover property (reg_rd && reg_addr == sem_pkg::OFS_MODE);
endmodule : sem_reg_bank

// ---- verilog/sem_pkg.sv ----
// Constants for the host-port error mask and device configuration register bank
// Notes on behaviour
// - Set mask bit hides matching error bit from the summary
// - Mask resets to zero; reserved bits read zero
// - Config region 0x0800-0x08FF; unassigned reads zero
// - Mode register resets to 0xC8000468
// - Listed mode bits survive sleep entry
// - Listed flag and enable bits survive sleep
// - Wake edge field: off, rise, fall, both
// - Summary bit set by any unmasked error
// - Error bits sticky, write one clears
package sem_pkg;
   // ==========================================================
   // Register map
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam logic [15:0] OFS_ERR_STATUS = 16'h000C;
   localparam logic [15:0] OFS_ERR_MASK = 16'h0010;
   localparam logic [15:0] OFS_MODE = 16'h0800;
   localparam logic [15:0] OFS_PRESCALE = 16'h0804;
   localparam logic [15:0] OFS_SCRATCH = 16'h0808;
   localparam logic [15:0] OFS_ECC0 = 16'h080C;
   localparam logic [15:0] OFS_ECC1 = 16'h0810;
   localparam logic [15:0] OFS_DEV_FLAGS = 16'h0820;
   localparam logic [15:0] OFS_CTRL_FLAGS = 16'h0824;
   localparam logic [15:0] OFS_INT_EN = 16'h0830;
   localparam logic [15:0] CFG_BASE = 16'h0800;
   localparam logic [15:0] CFG_LAST = 16'h08FF;
   // ==========================================================
   // Error status and mask fields
   localparam logic [31:0] ERR_BITS = 32'h3F3F0000;
   localparam logic [31:0] SPI_ERR_BITS = 32'h003F0000;
   localparam logic [31:0] INT_ERR_BITS = 32'h3F000000;
   localparam int SUM_SPI_BIT = 1;
   localparam int SUM_INT_BIT = 2;
   // ==========================================================
   // Reset values and write masks
   localparam logic [31:0] RST_ZERO = 32'h00000000;
   localparam logic [31:0] RST_MODE = 32'hC8000468;
   localparam logic [31:0] RST_PRESCALE = 32'h00000002;
   localparam logic [31:0] RST_INT_EN = 32'h0FFFFFFF;
   localparam logic [31:0] MODE_WR_MASK = 32'hF8EFEFCF;
   // ==========================================================
   // Sleep retention
   localparam logic [31:0] RET_MODE = 32'hC0E8EF03;
   localparam logic [31:0] RET_FLAGS = 32'h002C0000;
   localparam logic [31:0] RET_INT_EN = 32'h0000C000;
   // ==========================================================
   // Wake edge field
   localparam int WAKE_LSB = 30;
   localparam logic [1:0] WAKE_OFF = 2'h0;
   localparam logic [1:0] WAKE_RISE = 2'h1;
   localparam logic [1:0] WAKE_FALL = 2'h2;
   localparam logic [1:0] WAKE_BOTH = 2'h3;
endpackage : sem_pkg

// ---- verilog/sem_wake_detect.sv ----
// Wake pin synchroniser and edge decoder
module sem_wake_detect (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic wake_pin,
   input wire logic [1:0] wake_cfg,
   output logic wake_event
);
   logic sync1;
   logic sync2;
   logic sync3;
   logic next_wake_event;
   logic rise;
   logic fall;

   // ==========================================================
   // Synchroniser; only sync2 onward is looked at
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end else begin
         sync1 <= wake_pin;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // ==========================================================
   // Edge decode
   always_comb begin
      rise = sync2 & ~sync3;
      fall = ~sync2 & sync3;
      case (wake_cfg)
         sem_pkg::WAKE_OFF: next_wake_event = 1'b0;
         sem_pkg::WAKE_RISE: next_wake_event = rise;
         sem_pkg::WAKE_FALL: next_wake_event = fall;
         sem_pkg::WAKE_BOTH: next_wake_event = rise | fall;
         default: next_wake_event = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wake_event <= 1'b0;
      end else begin
         wake_event <= next_wake_event;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   a_wake_off_quiet: assert property (
      $past(wake_cfg) == sem_pkg::WAKE_OFF |-> !wake_event)
      else $error("wake event while detection disabled");
   a_wake_rise_seen: assert property (
      (wake_cfg == sem_pkg::WAKE_RISE) && sync2 && !sync3 |=> wake_event)
      else $error("rising wake edge missed");
   c_wake_fall: cover property ((wake_cfg == sem_pkg::WAKE_FALL) && wake_event);
endmodule : sem_wake_detect

// ---- tb/sem_far_model.sv ----
// Far-side model: error sources, flag levels and wake pin
module sem_far_model (
   input wire logic mclk,
   output logic [31:0] err_event,
   output logic [31:0] dev_flags,
   output logic [31:0] ctrl_flags,
   output logic wake_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   // ========
   // Stimulus
   initial begin
      err_event = 32'h00000000;
      dev_flags = 32'hFFFFFFFF;
      ctrl_flags = 32'h0000A5A5;
      wake_pin = 1'b0;
   end
   // Error sources pulse for exactly one clock
   task automatic raise_err(input logic [31:0] bits);
      @(negedge mclk);
      err_event = bits;
      @(negedge mclk);
      err_event = 32'h00000000;
   endtask : raise_err
   // Held long enough to pass the two-flop synchroniser
   task automatic set_wake(input logic level);
      @(negedge mclk);
      wake_pin = level;
      repeat (6) @(negedge mclk);
   endtask : set_wake
endmodule : sem_far_model

// ---- tb/tb_top.sv ----
// Self-checking testbench for the error mask and configuration bank
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sleep_active = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [31:0] reg_wdata = 32'h00000000;
   logic [31:0] reg_rdata, err_event, dev_flags, ctrl_flags, err_status, mode_setup, int_en;
   logic reg_rvalid, wake_pin, spi_irq, int_irq, wake_event;
   int n_fail = 0;
   int n_checks = 0;
   int n_wake = 0;
   int cyc = 0;
   always #5 mclk = ~mclk;
   sem_far_model u_far (
      .mclk(mclk),
      .err_event(err_event),
      .dev_flags(dev_flags),
      .ctrl_flags(ctrl_flags),
      .wake_pin(wake_pin)
   );
   sem_reg_bank DUT (
      .mclk(mclk),
      .arst_n(arst_n),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid),
      .err_event(err_event),
      .sleep_active(sleep_active),
      .dev_flags_in(dev_flags),
      .ctrl_flags_in(ctrl_flags),
      .wake_pin(wake_pin),
      .err_status(err_status),
      .mode_setup(mode_setup),
      .timestamp_prescale(),
      .interrupt_enables(int_en),
      .spi_error_irq(spi_irq),
      .internal_error_irq(int_irq),
      .wake_event(wake_event)
   );
   // ========
   // Helpers
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr
   // Answer must be present in the cycle right after the strobe
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      chk({31'h00000000, reg_rvalid}, 32'h00000001);
      chk(reg_rdata, e);
   endtask : rd_chk
   always @(posedge mclk) begin
      cyc++;
      if (wake_event === 1'b1) begin
         n_wake++;
      end
      // Whole run needs well under a thousand cycles
      if (cyc == 3000) begin
         n_fail++;
         report_and_stop();
      end
   end
   // ========
   // Main sequence
   localparam logic [15:0] RADDR [8] = '{16'h0800, 16'h0804, 16'h0808, 16'h0830,
      16'h0010, 16'h0814, 16'h08FC, 16'h0824};
   localparam logic [31:0] RVAL [8] = '{32'hC8000468, 32'h00000002, 32'h00000000,
      32'h0FFFFFFF, 32'h00000000, 32'h00000000, 32'h00000000, 32'h0000A5A5};
   localparam int WEXP [4] = '{0, 1, 1, 2};
   localparam logic [29:0] RST_MODE_LOW = sem_pkg::RST_MODE[29:0];
   initial begin
      logic [31:0] mv;
      int w0;
      repeat (10) @(negedge mclk);
      arst_n = 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd_chk(RADDR[i], RVAL[i]);
      end
      wr(16'h0808, 32'h12345678);
      rd_chk(16'h0808, 32'h12345678);
      wr(16'h080C, 32'hA5A55A5A);
      rd_chk(16'h080C, 32'hA5A55A5A);
      wr(16'h0814, 32'h12345678);
      rd_chk(16'h0814, 32'h00000000);
      wr(16'h0010, 32'hFFFFFFFF);
      rd_chk(16'h0010, 32'h3F3F0000);
      wr(16'h0010, 32'h00010000);
      u_far.raise_err(32'h01010001);
      chk(err_status, 32'h01010000);
      chk({31'h00000000, spi_irq}, 32'h00000000);
      chk({31'h00000000, int_irq}, 32'h00000001);
      rd_chk(16'h000C, 32'h01010004);
      wr(16'h0010, 32'h00000000);
      @(negedge mclk);
      chk({31'h00000000, spi_irq}, 32'h00000001);
      wr(16'h000C, 32'h00000000);
      @(negedge mclk);
      chk(err_status, 32'h01010000);
      wr(16'h000C, 32'h01010000);
      @(negedge mclk);
      chk(err_status, 32'h00000000);
      chk({30'h00000000, spi_irq, int_irq}, 32'h00000000);
      for (int m = 0; m < 4; m++) begin
         wr(16'h0800, {2'(m), RST_MODE_LOW});
         repeat (4) @(negedge mclk);
         w0 = n_wake;
         u_far.set_wake(1'b1);
         u_far.set_wake(1'b0);
         chk(32'(n_wake - w0), 32'(WEXP[m]));
      end
      mv = 32'hFFFBFFFB;
      wr(16'h0800, mv);
      mv = (mv & sem_pkg::MODE_WR_MASK) | (sem_pkg::RST_MODE & ~sem_pkg::MODE_WR_MASK);
      chk(mode_setup, mv);
      // Bit 15 set and bit 14 clear, so both kept levels are seen
      wr(16'h0830, 32'h00008000);
      @(negedge mclk);
      sleep_active = 1'b1;
      repeat (2) @(negedge mclk);
      chk(mode_setup, (mv & sem_pkg::RET_MODE) | (sem_pkg::RST_MODE & ~sem_pkg::RET_MODE));
      mv = (32'h00008000 & sem_pkg::RET_INT_EN) | (sem_pkg::RST_INT_EN & ~sem_pkg::RET_INT_EN);
      chk(int_en, mv);
      rd_chk(16'h0820, sem_pkg::RET_FLAGS);
      report_and_stop();
   end
endmodule : tb_top
